// ### bench/tbp_load.sv
`timescale 1ns/1ps
// external loads on the four outputs: count high cycles and rises
module tbp_load
(
  input  wire logic             pclk,     // system clock
  input  wire logic             clr,      // restart the count window
  input  wire logic [3:0]       pwm_in,   // outputs under load
  output logic      [3:0][15:0] hi_cnt,   // cycles seen high
  output logic      [3:0][15:0] rise_cnt  // low to high changes
);
  logic [3:0] prev_reg;  // level at the previous edge

  // a window of whole periods gives exact counts whatever the phase
  always_ff @(posedge pclk)
  begin
    prev_reg <= pwm_in;
    for (int c = 0; c < 4; c++)
    begin
      if (clr)
      begin
        hi_cnt[c]   <= 16'h0000;
        rise_cnt[c] <= 16'h0000;
      end
      else
      begin
        hi_cnt[c]   <= hi_cnt[c] + {15'h0000, pwm_in[c]};
        rise_cnt[c] <= rise_cnt[c] + {15'h0000, pwm_in[c] & ~prev_reg[c]};
      end
    end
  end
endmodule // tbp_load

// ### bench/twelve_bit_pwm_channel_config_tb_top.sv
`timescale 1ns/1ps
// bench: register access, waveforms, clock sources and low power
module twelve_bit_pwm_channel_config_tb_top;
  import tbp_pkg::*;

  logic             pclk, presetn, psel, penable, pwrite;  // apb side
  logic [11:0]      paddr;                 // byte address
  logic [31:0]      pwdata, prdata, rd;    // write, read, last read
  logic [3:0]       pstrb, pwm_out;        // strobes, outputs
  logic             pready, pslverr, er;   // answer, error, last error
  logic             hirc_clk, lirc_clk;    // oscillator pins
  logic             stop_mode, sleep_mode; // low-power levels
  logic             clr;                   // load window restart
  logic [3:0][15:0] hi_cnt, rise_cnt;      // load counts
  int               error_cnt, num_checks; // verdict counters

  // one waveform case on group 0, channel 0
  typedef struct {
    logic [7:0] ctrl;
    int         per;
    int         duty;
    int         win;
    int         hi;
    int         rs;
  } tbp_row_t;

  // control, period, duty, window, high cycles, rises; -1 not checked
  tbp_row_t rows[8] = '{
    '{8'h00, 9, 4, 100, 50, 10},    // standard
    '{8'h00, 9, 1, 100, 20, 10},    // standard, short duty
    '{8'h80, 9, 1, 100, 80, 10},    // active low
    '{8'h01, 9, 1, 200, 40, 10},    // divide by 2
    '{8'h07, 1, 0, 512, 256, 2},    // divide by 128
    '{8'h40, 9, 4, 200, 100, 10},   // toggle on match
    '{8'h20, 9, 4, 100, -1, 10},    // set on match
    '{8'h60, 9, 4, 180, 90, -1}     // center aligned
  };

  // source, stop, sleep, expected running
  logic [4:0] pw[6] = '{5'b00_1_0_0, 5'b01_1_0_1, 5'b01_0_1_0,
                        5'b10_1_1_1, 5'b11_0_0_0, 5'b00_0_0_1};

  tbp_pwm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .hirc_clk(hirc_clk), .lirc_clk(lirc_clk), .stop_mode(stop_mode),
    .sleep_mode(sleep_mode), .pwm_out(pwm_out));

  tbp_load u_load (.pclk(pclk), .clr(clr), .pwm_in(pwm_out),
    .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

  // clocks: 50 MHz system, oscillators unrelated in phase
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    hirc_clk = 1'b0;
    #3;
    forever #30 hirc_clk = ~hirc_clk;
  end
  initial
  begin
    lirc_clk = 1'b0;
    #7;
    forever #50 lirc_clk = ~lirc_clk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // counts, verdict, end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      error_cnt++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read one register and compare
  task automatic rchk(input string nm, input logic [7:0] idx,
                      input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, exp, rd);
  endtask

  // program group 0 and channel 0, high bytes first, then settle
  task automatic cfg(input logic [7:0] c, input int p, input int d);
    apb(1'b1, CH0_CONTROL_IDX, c);
    apb(1'b1, CH0_PERIOD_HIGH_IDX, 8'(p >> 8));
    apb(1'b1, CH0_PERIOD_LOW_IDX, 8'(p));
    apb(1'b1, CH0_DUTY_HIGH_IDX, 8'(d >> 8));
    apb(1'b1, CH0_DUTY_LOW_IDX, 8'(d));
    repeat (300) @(posedge pclk);
  endtask

  // count the loads over n cycles
  task automatic meas(input int n);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    stop_mode = 1'b0;
    sleep_mode = 1'b0;
    clr = 1'b1;
    error_cnt = 0;
    num_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("out", 32'h0, {28'h0, pwm_out});
    foreach (rows[i])
    begin
      cfg(rows[i].ctrl, rows[i].per, rows[i].duty);
      meas(rows[i].win);
      if (rows[i].hi >= 0)
        chk("hi", 32'(rows[i].hi), {16'h0, hi_cnt[0]});
      if (rows[i].rs >= 0)
        chk("rises", 32'(rows[i].rs), {16'h0, rise_cnt[0]});
    end
    // awkward cases: channel 3 on group 0 settings
    cfg(8'h00, 9, 4);
    apb(1'b1, CH3_DUTY_HIGH_IDX, 8'h00);
    apb(1'b1, CH3_DUTY_LOW_IDX, 8'h07);
    repeat (300) @(posedge pclk);
    meas(100);
    chk("ch3 hi", 32'd80, {16'h0, hi_cnt[3]});
    chk("ch0 hi", 32'd50, {16'h0, hi_cnt[0]});
    // clock sources against stop and sleep
    foreach (pw[i])
    begin
      cfg({3'b000, pw[i][4:3], 3'b000}, 9, 4);
      stop_mode  <= pw[i][2];
      sleep_mode <= pw[i][1];
      // let a halted counter settle before the window opens
      repeat (4) @(posedge pclk);
      meas(400);
      chk("run", {31'h0, pw[i][0]},
          {31'h0, rise_cnt[0] != 16'h0});
      // levels change on a rising edge only
      @(posedge pclk);
      stop_mode  <= 1'b0;
      sleep_mode <= 1'b0;
    end
    // register access and read-only upper bits
    for (int g = 0; g < NUM_GRP; g++)
    begin
      apb(1'b1, CTRL_IDX_TAB[g], 8'hA5);
      rchk("ctrl", CTRL_IDX_TAB[g], 32'h0000_00A5);
      apb(1'b1, PH_IDX_TAB[g], 8'hFF);
      rchk("per hi", PH_IDX_TAB[g], 32'h0000_000F);
      apb(1'b1, PL_IDX_TAB[g], 8'h5A);
      rchk("per lo", PL_IDX_TAB[g], 32'h0000_005A);
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      apb(1'b1, DH_IDX_TAB[c], 8'hFF);
      rchk("duty hi", DH_IDX_TAB[c], 32'h0000_000F);
      apb(1'b1, DL_IDX_TAB[c], 8'h3C);
      rchk("duty lo", DL_IDX_TAB[c], 32'h0000_003C);
    end
    // groups 1 and 2 on their own settings, active low, duty 2 of 9
    for (int g = 1; g < NUM_GRP; g++)
    begin
      apb(1'b1, CTRL_IDX_TAB[g], 8'h80);
      apb(1'b1, PH_IDX_TAB[g], 8'h00);
      apb(1'b1, PL_IDX_TAB[g], 8'h09);
      apb(1'b1, DH_IDX_TAB[g], 8'h00);
      apb(1'b1, DL_IDX_TAB[g], 8'h02);
    end
    meas(100);
    chk("ch1 hi", 32'd70, {16'h0, hi_cnt[1]});
    chk("ch2 hi", 32'd70, {16'h0, hi_cnt[2]});
    // unmapped place: error, write dropped, read zero
    apb(1'b1, 8'h10, 8'hFF);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h10, 8'h00);
    chk("unmapped rd", 32'h0, rd);
    // reset in mid-run clears everything
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int g = 0; g < NUM_GRP; g++)
    begin
      rchk("rst ctrl", CTRL_IDX_TAB[g], 32'h0);
      rchk("rst per hi", PH_IDX_TAB[g], 32'h0);
      rchk("rst per lo", PL_IDX_TAB[g], 32'h0);
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      rchk("rst duty hi", DH_IDX_TAB[c], 32'h0);
      rchk("rst duty lo", DL_IDX_TAB[c], 32'h0);
    end
    chk("rst out", 32'h0, {28'h0, pwm_out});
    print_verdict();
  end
endmodule // twelve_bit_pwm_channel_config_tb_top

// ### inc/tbp_pkg.sv
// Notes on behaviour
// - polarity bit: 0 active high, 1 active low
// - mode: standard, set on match, toggle, center
// - clock: peripheral, fast, slow; 11 test only
// - fast clock runs in stop, halts in sleep
// - slow clock runs in stop and sleep
// - prescale code n divides by two power n
// - period high nibble, upper bits read zero
// - duty high nibble, upper bits read zero
// - reset clears every field and value
// - channel 3 owns a 12-bit duty value
// - write high first; low write loads, starts
// - channels 0/3 share group 0 settings
// - standard mode duty ratio is (duty+1)/(period+1)
// - run in idle, stop and sleep halt peripheral clock
package tbp_pkg;

  localparam int NUM_GRP = 3;  // counter groups with period and control
  localparam int NUM_CH  = 4;  // outputs, each with its own duty value

  // register indices; byte address is four times the index
  localparam logic [7:0] CH3_DUTY_LOW_IDX    = 8'hE5;
  localparam logic [7:0] CH3_DUTY_HIGH_IDX   = 8'hE6;
  localparam logic [7:0] CH2_CONTROL_IDX     = 8'hEA;
  localparam logic [7:0] CH2_PERIOD_LOW_IDX  = 8'hEB;
  localparam logic [7:0] CH2_PERIOD_HIGH_IDX = 8'hEC;
  localparam logic [7:0] CH2_DUTY_LOW_IDX    = 8'hED;
  localparam logic [7:0] CH2_DUTY_HIGH_IDX   = 8'hEE;
  localparam logic [7:0] CH1_CONTROL_IDX     = 8'hF2;
  localparam logic [7:0] CH1_PERIOD_LOW_IDX  = 8'hF3;
  localparam logic [7:0] CH1_PERIOD_HIGH_IDX = 8'hF4;
  localparam logic [7:0] CH1_DUTY_LOW_IDX    = 8'hF5;
  localparam logic [7:0] CH1_DUTY_HIGH_IDX   = 8'hF6;
  localparam logic [7:0] CH0_CONTROL_IDX     = 8'hFA;
  localparam logic [7:0] CH0_PERIOD_LOW_IDX  = 8'hFB;
  localparam logic [7:0] CH0_PERIOD_HIGH_IDX = 8'hFC;
  localparam logic [7:0] CH0_DUTY_LOW_IDX    = 8'hFD;
  localparam logic [7:0] CH0_DUTY_HIGH_IDX   = 8'hFE;

  // lookup tables indexed by group or channel number
  localparam logic [2:0][7:0] CTRL_IDX_TAB =
    {CH2_CONTROL_IDX, CH1_CONTROL_IDX, CH0_CONTROL_IDX};
  localparam logic [2:0][7:0] PL_IDX_TAB =
    {CH2_PERIOD_LOW_IDX, CH1_PERIOD_LOW_IDX, CH0_PERIOD_LOW_IDX};
  localparam logic [2:0][7:0] PH_IDX_TAB =
    {CH2_PERIOD_HIGH_IDX, CH1_PERIOD_HIGH_IDX, CH0_PERIOD_HIGH_IDX};
  localparam logic [3:0][7:0] DL_IDX_TAB =
    {CH3_DUTY_LOW_IDX, CH2_DUTY_LOW_IDX, CH1_DUTY_LOW_IDX,
     CH0_DUTY_LOW_IDX};
  localparam logic [3:0][7:0] DH_IDX_TAB =
    {CH3_DUTY_HIGH_IDX, CH2_DUTY_HIGH_IDX, CH1_DUTY_HIGH_IDX,
     CH0_DUTY_HIGH_IDX};

  // control register field positions
  localparam int POL_BIT  = 7;
  localparam int MODE_HI  = 6;
  localparam int MODE_LO  = 5;
  localparam int CS_HI    = 4;
  localparam int CS_LO    = 3;
  localparam int PS_HI    = 2;
  localparam int PS_LO    = 0;

  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [11:0] VAL_RST  = 12'h000;
  localparam logic [3:0]  HIGH_RST = 4'h0;

  // clock rate of pclk
  localparam int PCLK_HZ = 50_000_000;

  // working modes in code order 00..11
  typedef enum logic [1:0] {
    TBP_MODE_STD, TBP_MODE_SET, TBP_MODE_TOG, TBP_MODE_CTR
  } tbp_mode_t;

  // clock sources in code order 00..11
  typedef enum logic [1:0] {
    TBP_CLK_PER, TBP_CLK_FAST, TBP_CLK_SLOW, TBP_CLK_TEST
  } tbp_clk_t;

endpackage

// ### rtl/tbp_pwm_out.sv
`timescale 1ns/1ps
// one modulated output: compares the shared counter with its duty value
module tbp_pwm_out
  import tbp_pkg::*;
(
  input  wire logic        pclk,     // system clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        tick,     // prescaled count enable
  input  wire logic        run,      // output started by software
  input  wire tbp_mode_t   mode,     // working mode
  input  wire logic        pol,      // 1 inverts the active level
  input  wire logic [11:0] duty,     // duty value
  input  wire logic [11:0] per,      // period value
  input  wire logic [11:0] cnt,      // shared group counter
  output logic             out       // modulated output
);

  logic held_reg;  // latched level for match modes
  logic match;     // counter equals duty
  logic wrap;      // counter at period end
  logic act;       // active state before polarity

  // compare terms
  always_comb
  begin
    match = (cnt == duty);
    wrap  = (cnt >= per);
    if (mode == TBP_MODE_STD || mode == TBP_MODE_CTR)
      act = (cnt <= duty);
    else
      act = held_reg;
  end

  // latched level for set and toggle modes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      held_reg <= 1'b0;
    else if (!run)
      held_reg <= 1'b0;
    else if (tick)
    begin
      unique case (mode)
        TBP_MODE_SET:  // set on match, clear at period end
          if (match)
            held_reg <= 1'b1;
          else if (wrap)
            held_reg <= 1'b0;
        TBP_MODE_TOG:  // flip on each match
          if (match)
            held_reg <= ~held_reg;
        TBP_MODE_STD, TBP_MODE_CTR:
          held_reg <= held_reg;
      endcase
    end
  end

  // registered output with polarity applied
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out <= 1'b0;
    else
      out <= run ? (act ^ pol) : pol;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  idle_level_a: assert property (!run |=> out == $past(pol))
    else $error("stopped output not at inactive level");
  std_level_a: assert property (
    run && mode == TBP_MODE_STD |=>
      out == (($past(cnt) <= $past(duty)) ^ $past(pol)))
    else $error("standard mode level wrong");
  toggle_flip_a: assert property (
    run && mode == TBP_MODE_TOG && tick && match |=>
      held_reg != $past(held_reg))
    else $error("toggle mode did not flip on match");

endmodule // tbp_pwm_out

// ### rtl/tbp_pwm_top.sv
`timescale 1ns/1ps
// twelve-bit pwm channels with apb register access
module tbp_pwm_top
  import tbp_pkg::*;
(
  input  wire logic        pclk,        // system clock, 50 MHz
  input  wire logic        presetn,     // async reset, active low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb write
  input  wire logic [11:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  input  wire logic [3:0]  pstrb,       // apb byte strobes
  output logic             pready,      // apb ready
  output logic [31:0]      prdata,      // apb read data
  output logic             pslverr,     // apb error, unmapped address
  input  wire logic        hirc_clk,    // fast oscillator, async pin
  input  wire logic        lirc_clk,    // slow oscillator, async pin
  input  wire logic        stop_mode,   // stop low-power mode
  input  wire logic        sleep_mode,  // sleep low-power mode
  output logic [3:0]       pwm_out      // modulated outputs
);

  logic [7:0]  ctrl_reg    [NUM_GRP];  // control per group
  logic [11:0] per_reg     [NUM_GRP];  // active period value
  logic [3:0]  per_hi_reg  [NUM_GRP];  // staged period high nibble
  logic [11:0] duty_reg    [NUM_CH];   // active duty value
  logic [3:0]  duty_hi_reg [NUM_CH];   // staged duty high nibble
  logic [3:0]  run_reg;                // output started
  logic [6:0]  psc_reg     [NUM_GRP];  // prescaler count
  logic [11:0] cnt_reg     [NUM_GRP];  // group counter
  logic [2:0]  dir_reg;                // center mode counting down
  logic [2:0]  hirc_sync_reg;          // fast clock sync and edge
  logic [2:0]  lirc_sync_reg;          // slow clock sync and edge

  logic [2:0]  hit_ctrl;   // control register addressed
  logic [2:0]  hit_pl;     // period low addressed
  logic [2:0]  hit_ph;     // period high addressed
  logic [3:0]  hit_dl;     // duty low addressed
  logic [3:0]  hit_dh;     // duty high addressed
  logic        any_hit;    // mapped address
  logic        word_ok;    // aligned, in range
  logic [7:0]  idx;        // register index
  logic        wr_en;      // write takes effect
  logic        setup;      // apb setup cycle
  logic [31:0] rdata_next; // read data for the addressed register
  logic        fast_en;    // fast oscillator rising edge
  logic        slow_en;    // slow oscillator rising edge
  logic [2:0]  src_en;     // selected source enable per group
  logic [2:0]  tick;       // prescaled enable per group
  logic [2:0]  grp_run;    // group has a started output

  // group that owns the period and control of a channel
  function automatic int chan_grp(input int c);
    return (c == 3) ? 0 : c;
  endfunction

  // prescaler reaches the end of a 2^n divide
  function automatic logic psc_hit(input logic [6:0] c,
                                   input logic [2:0] n);
    logic [7:0] full;
    full = (8'h01 << n) - 8'h01;
    return (c & full[6:0]) == full[6:0];
  endfunction

  // address decode
  always_comb
  begin
    word_ok  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    idx      = paddr[9:2];
    hit_ctrl = '0;
    hit_pl   = '0;
    hit_ph   = '0;
    hit_dl   = '0;
    hit_dh   = '0;
    for (int g = 0; g < NUM_GRP; g++)
    begin
      hit_ctrl[g] = word_ok && (idx == CTRL_IDX_TAB[g]);
      hit_pl[g]   = word_ok && (idx == PL_IDX_TAB[g]);
      hit_ph[g]   = word_ok && (idx == PH_IDX_TAB[g]);
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      hit_dl[c] = word_ok && (idx == DL_IDX_TAB[c]);
      hit_dh[c] = word_ok && (idx == DH_IDX_TAB[c]);
    end
    any_hit = |{hit_ctrl, hit_pl, hit_ph, hit_dl, hit_dh};
  end

  // apb handshake, no wait states
  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite && pstrb[0] && any_hit;

  // read mux, upper nibble of high registers reads zero
  always_comb
  begin
    rdata_next = '0;
    for (int g = 0; g < NUM_GRP; g++)
    begin
      if (hit_ctrl[g])
        rdata_next[7:0] = ctrl_reg[g];
      if (hit_pl[g])
        rdata_next[7:0] = per_reg[g][7:0];
      if (hit_ph[g])
        rdata_next[3:0] = per_hi_reg[g];
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (hit_dl[c])
        rdata_next[7:0] = duty_reg[c][7:0];
      if (hit_dh[c])
        rdata_next[3:0] = duty_hi_reg[c];
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
      pslverr <= !any_hit;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int g = 0; g < NUM_GRP; g++)
        ctrl_reg[g] <= CTRL_RST;
    else if (wr_en)
      for (int g = 0; g < NUM_GRP; g++)
        if (hit_ctrl[g])
          ctrl_reg[g] <= pwdata[7:0];
  end

  // period values: high stages, low loads the whole value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int g = 0; g < NUM_GRP; g++)
      begin
        per_reg[g]    <= VAL_RST;
        per_hi_reg[g] <= HIGH_RST;
      end
    else if (wr_en)
      for (int g = 0; g < NUM_GRP; g++)
      begin
        if (hit_ph[g])
          per_hi_reg[g] <= pwdata[3:0];
        if (hit_pl[g])
          per_reg[g] <= {per_hi_reg[g], pwdata[7:0]};
      end
  end

  // duty values: same staging as the period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int c = 0; c < NUM_CH; c++)
      begin
        duty_reg[c]    <= VAL_RST;
        duty_hi_reg[c] <= HIGH_RST;
      end
    else if (wr_en)
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (hit_dh[c])
          duty_hi_reg[c] <= pwdata[3:0];
        if (hit_dl[c])
          duty_reg[c] <= {duty_hi_reg[c], pwdata[7:0]};
      end
  end

  // a low-byte write starts the output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_reg <= '0;
    else if (wr_en)
      for (int c = 0; c < NUM_CH; c++)
        if (hit_dl[c] || hit_pl[chan_grp(c)])
          run_reg[c] <= 1'b1;
  end

  // oscillator pins: two flops, then a third for edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hirc_sync_reg <= '0;
      lirc_sync_reg <= '0;
    end
    else
    begin
      hirc_sync_reg <= {hirc_sync_reg[1:0], hirc_clk};
      lirc_sync_reg <= {lirc_sync_reg[1:0], lirc_clk};
    end
  end

  assign fast_en = hirc_sync_reg[1] && !hirc_sync_reg[2];
  assign slow_en = lirc_sync_reg[1] && !lirc_sync_reg[2];

  // source enable per group, peripheral and fast sources gated by low-power modes
  always_comb
  begin
    for (int g = 0; g < NUM_GRP; g++)
    begin
      grp_run[g] = run_reg[g] || (g == 0 && run_reg[3]);
      unique case (tbp_clk_t'(ctrl_reg[g][CS_HI:CS_LO]))
        TBP_CLK_PER:
          src_en[g] = !stop_mode && !sleep_mode;
        TBP_CLK_FAST:
          src_en[g] = fast_en && !sleep_mode;
        TBP_CLK_SLOW:
          src_en[g] = slow_en;
        TBP_CLK_TEST:
          src_en[g] = 1'b0;
      endcase
      tick[g] = src_en[g] && grp_run[g] &&
                psc_hit(psc_reg[g], ctrl_reg[g][PS_HI:PS_LO]);
    end
  end

  // prescaler counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int g = 0; g < NUM_GRP; g++)
        psc_reg[g] <= '0;
    else
      for (int g = 0; g < NUM_GRP; g++)
        if (!grp_run[g])
          psc_reg[g] <= '0;
        else if (src_en[g])
          psc_reg[g] <= psc_reg[g] + 7'h01;
  end

  // group counters: up and wrap, or up-down when center-aligned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_reg <= '0;
      for (int g = 0; g < NUM_GRP; g++)
        cnt_reg[g] <= VAL_RST;
    end
    else
      for (int g = 0; g < NUM_GRP; g++)
        if (wr_en && hit_pl[g])
        begin
          cnt_reg[g] <= VAL_RST;  // restart on a new period
          dir_reg[g] <= 1'b0;
        end
        else if (tick[g])
        begin
          if (ctrl_reg[g][MODE_HI:MODE_LO] != TBP_MODE_CTR)
          begin
            dir_reg[g] <= 1'b0;
            if (cnt_reg[g] >= per_reg[g])
              cnt_reg[g] <= VAL_RST;
            else
              cnt_reg[g] <= cnt_reg[g] + 12'h001;
          end
          else if (!dir_reg[g])  // center mode, rising half
          begin
            if (cnt_reg[g] >= per_reg[g])
            begin
              dir_reg[g] <= 1'b1;
              cnt_reg[g] <= (cnt_reg[g] == VAL_RST) ? VAL_RST :
                            cnt_reg[g] - 12'h001;
            end
            else
              cnt_reg[g] <= cnt_reg[g] + 12'h001;
          end
          else if (cnt_reg[g] == VAL_RST)  // center mode, bottom
          begin
            dir_reg[g] <= 1'b0;
            cnt_reg[g] <= (per_reg[g] == VAL_RST) ? VAL_RST : 12'h001;
          end
          else
            cnt_reg[g] <= cnt_reg[g] - 12'h001;
        end
  end

  // one output per channel; channel 3 follows group 0
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_out
    localparam int G = chan_grp(c);
    tbp_pwm_out u_out (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick[G]),
      .run     (run_reg[c]),
      .mode    (tbp_mode_t'(ctrl_reg[G][MODE_HI:MODE_LO])),
      .pol     (ctrl_reg[G][POL_BIT]),
      .duty    (duty_reg[c]),
      .per     (per_reg[G]),
      .cnt     (cnt_reg[G]),
      .out     (pwm_out[c])
    );
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pl0_write;
    wr_en && hit_pl[0];
  endsequence

  reset_clear_a: assert property ($rose(presetn) |->
    ctrl_reg[0] == CTRL_RST && per_reg[0] == VAL_RST && run_reg == 4'h0)
    else $error("fields not cleared by reset");
  low_load_a: assert property (s_pl0_write |=>
    per_reg[0] == {$past(per_hi_reg[0]), $past(pwdata[7:0])}
    && run_reg[0])
    else $error("period low write did not load or start");
  high_stage_a: assert property (
    wr_en && hit_ph[1] |=> $stable(per_reg[1]))
    else $error("period high write changed active value");
  per_hi_zero_a: assert property (
    setup && !pwrite && hit_ph[2] |=> prdata[31:4] == 28'h0000000)
    else $error("period high upper bits not zero");
  duty_hi_zero_a: assert property (
    setup && !pwrite && hit_dh[3] |=> prdata[31:4] == 28'h0000000)
    else $error("duty high upper bits not zero");
  ch3_duty_a: assert property (
    wr_en && hit_dl[3] |=> duty_reg[3][7:0] == $past(pwdata[7:0]))
    else $error("channel 3 duty low not loaded");
  per_div1_a: assert property (
    grp_run[0] && !stop_mode && !sleep_mode &&
    ctrl_reg[0][CS_HI:PS_LO] == 5'h00 |-> tick[0])
    else $error("divide by one did not tick every cycle");
  stop_halt_a: assert property (
    stop_mode && ctrl_reg[0][CS_HI:CS_LO] == TBP_CLK_PER |-> !tick[0])
    else $error("peripheral clock counted in stop");
  fast_sleep_a: assert property (
    sleep_mode && ctrl_reg[0][CS_HI:CS_LO] == TBP_CLK_FAST |-> !tick[0])
    else $error("fast clock counted in sleep");
  slow_run_a: assert property (
    grp_run[0] && ctrl_reg[0][CS_HI:CS_LO] == TBP_CLK_SLOW &&
    ctrl_reg[0][PS_HI:PS_LO] == 3'h0 |-> tick[0] == slow_en)
    else $error("slow clock tick lost");
  test_sel_a: assert property (
    ctrl_reg[0][CS_HI:CS_LO] == TBP_CLK_TEST |-> !tick[0])
    else $error("reserved clock source counted");
  wrap_zero_a: assert property (
    tick[0] && !(wr_en && hit_pl[0]) && cnt_reg[0] >= per_reg[0] &&
    ctrl_reg[0][MODE_HI:MODE_LO] != TBP_MODE_CTR |=> cnt_reg[0] == VAL_RST)
    else $error("counter did not wrap to zero");

endmodule // tbp_pwm_top
